// [inc/ssa_defs.svh]
// constants for the scaled saturating adder: offsets, bit positions, resets, codes
`ifndef SSA_DEFS_SVH
`define SSA_DEFS_SVH

// datapath and field widths
`define SSA_DW          32
`define SSA_DEST_W      6
`define SSA_CC_W        5
`define SSA_PTR_OFS_W   5
`define SSA_PTR_ALIGN   2

// register port offsets
`define SSA_OFS_FLAGS   8'h00
`define SSA_OFS_RESULT  8'h04

// flag word bit positions
`define SSA_BIT_V       0
`define SSA_BIT_C       1
`define SSA_BIT_N       2
`define SSA_BIT_Z       3
`define SSA_BIT_SLO     4
`define SSA_BIT_SHI     5

// reset values
`define SSA_FLAGS_RST   1'b0
`define SSA_DATA_RST    32'h0000_0000
`define SSA_IDX_RST     6'h00

// saturation limits and null destination code
`define SSA_SAT_MAX     32'h7FFF_FFFF
`define SSA_SAT_MIN     32'h8000_0000
`define SSA_NULL_DEST   6'h3E

// scale shift amounts
`define SSA_SH_X1       2'h0
`define SSA_SH_X2       2'h1
`define SSA_SH_X4       2'h2
`define SSA_SH_X8       2'h3

// condition select codes
`define SSA_CC_AL       5'h00
`define SSA_CC_EQ       5'h01
`define SSA_CC_NE       5'h02
`define SSA_CC_PL       5'h03
`define SSA_CC_MI       5'h04
`define SSA_CC_CS       5'h05
`define SSA_CC_CC       5'h06
`define SSA_CC_VS       5'h07
`define SSA_CC_VC       5'h08
`define SSA_CC_GT       5'h09
`define SSA_CC_GE       5'h0A
`define SSA_CC_LT       5'h0B
`define SSA_CC_LE       5'h0C
`define SSA_CC_HI       5'h0D
`define SSA_CC_LS       5'h0E
`define SSA_CC_PNZ      5'h0F

`endif

// [inc/ssa_pkg.sv]
// types shared by the scaled saturating adder modules
package ssa_pkg;
`include "ssa_defs.svh"

  // operation selected by decode
  typedef enum logic [2:0] {
    add_plain,
    add_scaled_by_two,
    add_scaled_by_four,
    add_scaled_by_eight,
    saturating_signed_add
  } ssa_op_e;

  // complete state of the core
  typedef struct packed {
    logic                   wb_vld;
    logic [`SSA_DEST_W-1:0] wb_idx;
    logic [`SSA_DW-1:0]     wb_data;
    logic [`SSA_DW-1:0]     rdata;
    logic                   z;
    logic                   n;
    logic                   c;
    logic                   v;
    logic                   s_hi;
    logic                   s_lo;
  } ssa_state_s;

endpackage

// [inc/ssa_cc_if.sv]
// flags and condition select passed to the condition evaluator
`timescale 1ns/1ps
`include "ssa_defs.svh"
interface ssa_cc_if;
  logic                 z;
  logic                 n;
  logic                 c;
  logic                 v;
  logic [`SSA_CC_W-1:0] sel;
  logic                 hit;
  modport core (output z, n, c, v, sel, input hit);
  modport eval (input z, n, c, v, sel, output hit);
endinterface

// [rtl/ssa_cond.sv]
// condition code evaluator for conditional execution of every operation
`timescale 1ns/1ps
`include "ssa_defs.svh"
module ssa_cond
  import ssa_pkg::*;
(
  // flags in, verdict out
  ssa_cc_if.eval cc
);

  // signed compare helper: negative differs from overflow
  logic lt_w;
  assign lt_w = cc.n ^ cc.v;

  // decode of the condition select
  always_comb begin
    case (cc.sel)
      `SSA_CC_AL:  cc.hit = 1'b1;
      `SSA_CC_EQ:  cc.hit = cc.z;
      `SSA_CC_NE:  cc.hit = ~cc.z;
      `SSA_CC_PL:  cc.hit = ~cc.n;
      `SSA_CC_MI:  cc.hit = cc.n;
      `SSA_CC_CS:  cc.hit = cc.c;
      `SSA_CC_CC:  cc.hit = ~cc.c;
      `SSA_CC_VS:  cc.hit = cc.v;
      `SSA_CC_VC:  cc.hit = ~cc.v;
      `SSA_CC_GT:  cc.hit = ~cc.z & ~lt_w;
      `SSA_CC_GE:  cc.hit = ~lt_w;
      `SSA_CC_LT:  cc.hit = lt_w;
      `SSA_CC_LE:  cc.hit = cc.z | lt_w;
      `SSA_CC_HI:  cc.hit = ~cc.c & ~cc.z;
      `SSA_CC_LS:  cc.hit = cc.c | cc.z;
      `SSA_CC_PNZ: cc.hit = ~cc.n & ~cc.z;
      // unused codes never execute
      default:     cc.hit = 1'b0;
    endcase
  end

endmodule

// [rtl/ssa_core.sv]
// scaled and saturating integer add datapath with condition and flag logic
// How it works
// - plain add writes src1 plus src2
// - false condition: no write, no flags
// - flags change only with set-flags bit
// - pointer offset carries two implied zero bits
// - scale-by-two shifts src2 left one
// - scale-by-four shifts src2 left two
// - scale-by-eight shifts src2 left three
// - zero flag set when result zero
// - negative flag copies result bit 31
// - plain add: carry out, signed overflow
// - scaled overflow from addition step only
// - saturating add clamps to signed limits
// - saturating add: overflow flag equals saturation
// - saturation flag sticky, never cleared here
// - saturation sets both channel flags
// - saturating add carry from the addition
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "ssa_defs.svh"
module ssa_core
  import ssa_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input  logic                   clk_in,
  input  logic                   nrst_in,
  // instruction from decode
  input  logic                   issue_in,
  input  ssa_op_e                op_in,
  input  logic [`SSA_CC_W-1:0]   condition_select_in,
  input  logic                   set_flags_in,
  input  logic [`SSA_DEST_W-1:0] dest_idx_in,
  // operands
  input  logic [`SSA_DW-1:0]     src1_in,
  input  logic [`SSA_DW-1:0]     src2_in,
  input  logic                   src1_limm_in,
  input  logic                   src2_limm_in,
  input  logic [`SSA_DW-1:0]     limm_in,
  // short pointer form
  input  logic                   short_ptr_in,
  input  logic [`SSA_PTR_OFS_W-1:0] ptr_offset_in,
  // register port
  input  logic [ADDR_W-1:0]      reg_addr_in,
  input  logic [`SSA_DW-1:0]     reg_wdata_in,
  input  logic                   reg_wr_in,
  input  logic                   reg_rd_in,
  output logic [`SSA_DW-1:0]     reg_rdata_out,
  // destination write
  output logic                   wb_vld_out,
  output logic [`SSA_DEST_W-1:0] wb_idx_out,
  output logic [`SSA_DW-1:0]     wb_data_out,
  // flags
  output logic                   flag_zero_out,
  output logic                   flag_neg_out,
  output logic                   flag_carry_out,
  output logic                   flag_ovf_out,
  output logic                   high_channel_sat_flag_out,
  output logic                   low_channel_sat_flag_out
);

  // offsets must fit the address port
  if (ADDR_W < 3 || ADDR_W > 8) begin : g_bad_addr
    $error("ADDR_W must lie between 3 and 8");
  end

  // decoded register offsets at port width
  localparam logic [ADDR_W-1:0] OFS_FLAGS  = ADDR_W'(`SSA_OFS_FLAGS);
  localparam logic [ADDR_W-1:0] OFS_RESULT = ADDR_W'(`SSA_OFS_RESULT);

  ssa_state_s             st_q;     // registered state
  ssa_state_s             st_d;     // next state
  logic [`SSA_DW-1:0]     op_a;     // first operand after limm select
  logic [`SSA_DW-1:0]     op_b;     // second operand after select
  logic [`SSA_DW-1:0]     ptr_word; // aligned pointer offset
  logic [1:0]             sh_amt;   // scale shift
  logic [`SSA_DW-1:0]     b_sh;     // shifted second operand
  logic [`SSA_DW:0]       sum;      // sum with carry out
  logic                   ovf;      // signed overflow of the add step
  logic [`SSA_DW-1:0]     res;      // result after saturation
  logic                   is_sat;   // saturating operation
  logic                   fire;     // instruction executes
  logic                   null_dst; // destination is the null target
  logic [`SSA_DW-1:0]     flag_word; // flags packed for reads

  // condition evaluator link
  ssa_cc_if cc ();

  assign cc.z   = st_q.z;
  assign cc.n   = st_q.n;
  assign cc.c   = st_q.c;
  assign cc.v   = st_q.v;
  assign cc.sel = condition_select_in;

  // condition evaluator
  ssa_cond u_cond (
    .cc (cc.eval)
  );

  // execute only when issued and condition holds
  assign fire     = issue_in & cc.hit;
  assign null_dst = (dest_idx_in == `SSA_NULL_DEST);
  assign is_sat   = (op_in == saturating_signed_add);

  // word-aligned offset: low bits are implied zero
  assign ptr_word = {{(`SSA_DW-`SSA_PTR_OFS_W-`SSA_PTR_ALIGN){1'b0}},
                     ptr_offset_in, {`SSA_PTR_ALIGN{1'b0}}};

  // flags as seen on the register port
  always_comb begin
    flag_word = '0;
    flag_word[`SSA_BIT_V]   = st_q.v;
    flag_word[`SSA_BIT_C]   = st_q.c;
    flag_word[`SSA_BIT_N]   = st_q.n;
    flag_word[`SSA_BIT_Z]   = st_q.z;
    flag_word[`SSA_BIT_SLO] = st_q.s_lo;
    flag_word[`SSA_BIT_SHI] = st_q.s_hi;
  end

  // operand selection and arithmetic
  always_comb begin
    // long-immediate word replaces a register operand
    op_a = src1_limm_in ? limm_in : src1_in;
    if (short_ptr_in) begin
      op_b = ptr_word;
    end else if (src2_limm_in) begin
      op_b = limm_in;
    end else begin
      op_b = src2_in;
    end
    // scale amount per operation
    case (op_in)
      add_scaled_by_two:   sh_amt = `SSA_SH_X2;
      add_scaled_by_four:  sh_amt = `SSA_SH_X4;
      add_scaled_by_eight: sh_amt = `SSA_SH_X8;
      default:             sh_amt = `SSA_SH_X1;
    endcase
    // bits shifted out are simply dropped
    b_sh = op_b << sh_amt;
    sum  = {1'b0, op_a} + {1'b0, b_sh};
    // same-sign inputs giving a different sign overflow
    ovf  = (op_a[`SSA_DW-1] == b_sh[`SSA_DW-1]) &&
           (sum[`SSA_DW-1] != op_a[`SSA_DW-1]);
    // clamp toward the direction of overflow
    if (is_sat && ovf) begin
      res = op_a[`SSA_DW-1] ? `SSA_SAT_MIN : `SSA_SAT_MAX;
    end else begin
      res = sum[`SSA_DW-1:0];
    end
  end

  // next state: register port, then instruction effects
  always_comb begin
    st_d        = st_q;
    st_d.wb_vld = 1'b0;
    st_d.rdata  = '0;
    // software write of the flag word
    if (reg_wr_in && reg_addr_in == OFS_FLAGS) begin
      st_d.v    = reg_wdata_in[`SSA_BIT_V];
      st_d.c    = reg_wdata_in[`SSA_BIT_C];
      st_d.n    = reg_wdata_in[`SSA_BIT_N];
      st_d.z    = reg_wdata_in[`SSA_BIT_Z];
      st_d.s_lo = reg_wdata_in[`SSA_BIT_SLO];
      st_d.s_hi = reg_wdata_in[`SSA_BIT_SHI];
    end
    // instruction wins over a same-cycle software write
    if (fire) begin
      // result always produced, write suppressed for null target
      st_d.wb_vld  = ~null_dst;
      st_d.wb_idx  = dest_idx_in;
      st_d.wb_data = res;
      if (set_flags_in) begin
        st_d.z = (res == '0);
        st_d.n = res[`SSA_DW-1];
        st_d.c = sum[`SSA_DW];
        st_d.v = ovf;
        if (is_sat) begin
          // sticky: set on saturation, set beats clear
          st_d.s_hi = st_d.s_hi | ovf;
          st_d.s_lo = st_d.s_lo | ovf;
        end
      end
    end
    // read answers next cycle; unmapped reads give zero
    if (reg_rd_in) begin
      if (reg_addr_in == OFS_FLAGS) begin
        st_d.rdata = flag_word;
      end else if (reg_addr_in == OFS_RESULT) begin
        st_d.rdata = st_q.wb_data;
      end else begin
        st_d.rdata = '0;
      end
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st_q        <= '0;
      st_q.wb_idx <= `SSA_IDX_RST;
      st_q.wb_data <= `SSA_DATA_RST;
      st_q.z      <= `SSA_FLAGS_RST;
      st_q.s_hi   <= `SSA_FLAGS_RST;
      st_q.s_lo   <= `SSA_FLAGS_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign reg_rdata_out             = st_q.rdata;
  assign wb_vld_out                = st_q.wb_vld;
  assign wb_idx_out                = st_q.wb_idx;
  assign wb_data_out               = st_q.wb_data;
  assign flag_zero_out             = st_q.z;
  assign flag_neg_out              = st_q.n;
  assign flag_carry_out            = st_q.c;
  assign flag_ovf_out              = st_q.v;
  assign high_channel_sat_flag_out = st_q.s_hi;
  assign low_channel_sat_flag_out  = st_q.s_lo;

  // checks on the datapath
  default clocking ck @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // quiet issue: no software write in the same cycle
  logic quiet;
  assign quiet = ~reg_wr_in;

  plain_sum_a: assert property (
    fire && op_in == add_plain && !null_dst && !short_ptr_in
    |=> wb_vld_out && wb_data_out == $past(op_a + op_b))
    else $error("plain add result wrong");

  cond_skip_a: assert property (
    issue_in && !cc.hit && quiet |=> !wb_vld_out && $stable(flag_word))
    else $error("false condition changed state");

  flag_hold_a: assert property (
    fire && !set_flags_in && quiet |=> $stable(flag_word))
    else $error("flags changed without set-flags");

  ptr_align_a: assert property (
    fire && short_ptr_in && op_in == add_plain
    |=> wb_data_out == $past(op_a + {25'h0, ptr_offset_in, 2'h0}))
    else $error("pointer offset not word aligned");

  scale_two_a: assert property (
    fire && op_in == add_scaled_by_two
    |=> wb_data_out == $past(op_a + (op_b << 1)))
    else $error("scale by two result wrong");

  scale_four_a: assert property (
    fire && op_in == add_scaled_by_four
    |=> wb_data_out == $past(op_a + (op_b << 2)))
    else $error("scale by four result wrong");

  scale_eight_a: assert property (
    fire && op_in == add_scaled_by_eight
    |=> wb_data_out == $past(op_a + (op_b << 3)))
    else $error("scale by eight result wrong");

  zero_flag_a: assert property (
    fire && set_flags_in |=> flag_zero_out == (wb_data_out == '0))
    else $error("zero flag wrong");

  neg_flag_a: assert property (
    fire && set_flags_in |=> flag_neg_out == wb_data_out[`SSA_DW-1])
    else $error("negative flag wrong");

  plain_cv_a: assert property (
    fire && set_flags_in && op_in == add_plain
    |=> {flag_carry_out, wb_data_out} == $past({1'b0, op_a} + {1'b0, op_b})
        && flag_ovf_out == ($past(op_a[31] ~^ op_b[31])
                            && wb_data_out[31] != $past(op_a[31])))
    else $error("plain add carry or overflow wrong");

  scaled_ovf_a: assert property (
    fire && set_flags_in && !is_sat && op_in != add_plain
    |=> flag_ovf_out == ($past(op_a[31] ~^ b_sh[31])
                         && wb_data_out[31] != $past(op_a[31])))
    else $error("scaled overflow wrong");

  sat_value_a: assert property (
    fire && is_sat && ovf
    |=> wb_data_out == ($past(op_a[31]) ? `SSA_SAT_MIN : `SSA_SAT_MAX))
    else $error("saturated value wrong");

  sat_ovf_a: assert property (
    fire && set_flags_in && is_sat |=> flag_ovf_out == $past(ovf))
    else $error("saturation overflow flag wrong");

  sticky_hold_a: assert property (
    fire && set_flags_in && is_sat && !ovf && quiet
    |=> $stable(high_channel_sat_flag_out) && $stable(low_channel_sat_flag_out))
    else $error("sticky flag cleared");

  both_chan_a: assert property (
    fire && set_flags_in && is_sat && ovf
    |=> high_channel_sat_flag_out && low_channel_sat_flag_out)
    else $error("channel flags not both set");

  sat_carry_a: assert property (
    fire && set_flags_in && is_sat
    |=> flag_carry_out == $past(sum[`SSA_DW]))
    else $error("saturating carry wrong");

  null_dest_a: assert property (
    fire && null_dst |=> !wb_vld_out && wb_data_out == $past(res))
    else $error("null destination was written");

  limm_use_a: assert property (
    fire && src2_limm_in && !short_ptr_in && op_in == add_plain
    |=> wb_data_out == $past(op_a + limm_in))
    else $error("long immediate not used");

  // a write happens only in the cycle after an executing issue
  wb_pulse_a: assert property (
    !fire |=> !wb_vld_out)
    else $error("write without executing instruction");

  // read data stands one cycle, zero at every other time
  rd_idle_a: assert property (
    !reg_rd_in |=> reg_rdata_out == '0)
    else $error("read data outside its cycle");

  // flag read returns the packed flag levels of the strobe cycle
  flag_read_a: assert property (
    reg_rd_in && reg_addr_in == OFS_FLAGS
    |=> reg_rdata_out[5:0] == $past({high_channel_sat_flag_out, low_channel_sat_flag_out,
                                     flag_zero_out, flag_neg_out, flag_carry_out,
                                     flag_ovf_out})
        && reg_rdata_out[`SSA_DW-1:6] == '0)
    else $error("flag read wrong");

  // main scenarios
  plain_run_c: cover property (fire && op_in == add_plain ##1 wb_vld_out);
  sat_hit_c:   cover property (fire && is_sat && ovf && set_flags_in);
  skip_c:      cover property (issue_in && !cc.hit);
  null_c:      cover property (fire && null_dst && set_flags_in);
  sticky_c:    cover property (fire && is_sat && !ovf && set_flags_in && high_channel_sat_flag_out);

endmodule

// [bench/ssa_core_tb.sv]
// self-checking bench for the scaled saturating adder core
`timescale 1ns/1ps
`include "ssa_defs.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_total++; \
  $display("MISMATCH %s exp=%h got=%h", nm, ex, got); end end

module ssa_core_tb
  import ssa_pkg::*;
();
  // clock, reset and decode inputs
  logic        clk_in = 1'h0;
  logic        nrst_in;
  logic        issue_in;
  ssa_op_e     op_in;
  logic [4:0]  condition_select_in;
  logic        set_flags_in;
  logic [5:0]  dest_idx_in;
  logic [31:0] src1_in;
  logic [31:0] src2_in;
  logic        src1_limm_in;
  logic        src2_limm_in;
  logic [31:0] limm_in;
  logic        short_ptr_in;
  logic [4:0]  ptr_offset_in;
  logic [7:0]  reg_addr_in;
  logic [31:0] reg_wdata_in;
  logic        reg_wr_in;
  logic        reg_rd_in;
  // design outputs
  logic [31:0] reg_rdata_out;
  logic        wb_vld_out;
  logic [5:0]  wb_idx_out;
  logic [31:0] wb_data_out;
  logic        flag_zero_out;
  logic        flag_neg_out;
  logic        flag_carry_out;
  logic        flag_ovf_out;
  logic        high_channel_sat_flag_out;
  logic        low_channel_sat_flag_out;
  logic [5:0]  fl_now;        // flags in register-word order
  // reference state and bookkeeping
  logic [5:0]  exp_fl;
  logic [31:0] exp_wb;
  logic [5:0]  exp_idx;
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;

  assign fl_now = {high_channel_sat_flag_out, low_channel_sat_flag_out, flag_zero_out,
                   flag_neg_out, flag_carry_out, flag_ovf_out};

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  ssa_core #(.ADDR_W(8)) u_ssa_core (
    .clk_in(clk_in), .nrst_in(nrst_in), .issue_in(issue_in), .op_in(op_in),
    .condition_select_in(condition_select_in), .set_flags_in(set_flags_in),
    .dest_idx_in(dest_idx_in), .src1_in(src1_in), .src2_in(src2_in),
    .src1_limm_in(src1_limm_in), .src2_limm_in(src2_limm_in), .limm_in(limm_in),
    .short_ptr_in(short_ptr_in), .ptr_offset_in(ptr_offset_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .wb_vld_out(wb_vld_out),
    .wb_idx_out(wb_idx_out), .wb_data_out(wb_data_out), .flag_zero_out(flag_zero_out),
    .flag_neg_out(flag_neg_out), .flag_carry_out(flag_carry_out),
    .flag_ovf_out(flag_ovf_out), .high_channel_sat_flag_out(high_channel_sat_flag_out),
    .low_channel_sat_flag_out(low_channel_sat_flag_out));

  // reference condition evaluation, flags given as {s_hi,s_lo,z,n,c,v}
  function automatic logic cond_ok(logic [4:0] cc, logic [5:0] f);
    logic z, n, c, v;
    z = f[3];
    n = f[2];
    c = f[1];
    v = f[0];
    case (cc)
      `SSA_CC_AL:  return 1'h1;
      `SSA_CC_EQ:  return z;
      `SSA_CC_NE:  return !z;
      `SSA_CC_PL:  return !n;
      `SSA_CC_MI:  return n;
      `SSA_CC_CS:  return c;
      `SSA_CC_CC:  return !c;
      `SSA_CC_VS:  return v;
      `SSA_CC_VC:  return !v;
      `SSA_CC_GT:  return (n == v) && !z;
      `SSA_CC_GE:  return n == v;
      `SSA_CC_LT:  return n != v;
      `SSA_CC_LE:  return (n != v) || z;
      `SSA_CC_HI:  return !c && !z;
      `SSA_CC_LS:  return c || z;
      `SSA_CC_PNZ: return !n && !z;
      default:     return 1'h0;  // upper codes never execute
    endcase
  endfunction

  // one instruction; md: 0 registers, 1 src1 long imm, 2 src2 long imm, 3 short pointer
  task automatic exec(ssa_op_e op, logic [4:0] cc, logic fl, logic [5:0] dst,
                      logic [31:0] a, logic [31:0] b, int md);
    logic [31:0] bs, r;
    logic [32:0] s;
    logic        hit, v;
    bs = (md == 3) ? {25'h0, b[4:0], 2'h0} : b;
    case (op)
      add_scaled_by_two:   bs = bs << 1;
      add_scaled_by_four:  bs = bs << 2;
      add_scaled_by_eight: bs = bs << 3;
      default:             bs = bs;
    endcase
    s = {1'h0, a} + {1'h0, bs};
    r = s[31:0];
    // overflow of the addition step only; shifted-out bits play no part
    v = (a[31] == bs[31]) && (r[31] != a[31]);
    if (op == saturating_signed_add && v) r = a[31] ? `SSA_SAT_MIN : `SSA_SAT_MAX;
    hit = cond_ok(cc, exp_fl);
    @(posedge clk_in);
    issue_in <= 1'h1;
    op_in <= op;
    condition_select_in <= cc;
    set_flags_in <= fl;
    dest_idx_in <= dst;
    // the replaced register operand carries junk so a wrong pick shows
    src1_in <= (md == 1) ? ~a : a;
    src2_in <= (md >= 2) ? ~b : b;
    src1_limm_in <= (md == 1);
    src2_limm_in <= (md == 2);
    short_ptr_in <= (md == 3);
    limm_in <= (md == 1) ? a : b;
    ptr_offset_in <= b[4:0];
    @(posedge clk_in);
    issue_in <= 1'h0;
    if (hit) begin
      exp_wb = r;
      exp_idx = dst;
    end
    if (hit && fl) exp_fl = {exp_fl[5:4] | {2{op == saturating_signed_add && v}},
                             r == 32'h0, r[31], s[32], v};
    #1;
    `CHK("wb_vld", hit && dst != `SSA_NULL_DEST, wb_vld_out)
    `CHK("wb_data", exp_wb, wb_data_out)
    `CHK("wb_idx", exp_idx, wb_idx_out)
    `CHK("flags", exp_fl, fl_now)
  endtask

  // register write, one strobe cycle
  task automatic reg_wr(logic [7:0] ad, logic [31:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'h1;
    reg_addr_in <= ad;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'h0;
    if (ad == `SSA_OFS_FLAGS) exp_fl = d[5:0];
  endtask

  // register read; data stands one cycle only, then zero
  task automatic reg_rd(logic [7:0] ad, logic [31:0] ex);
    @(posedge clk_in);
    reg_rd_in <= 1'h1;
    reg_addr_in <= ad;
    @(posedge clk_in);
    reg_rd_in <= 1'h0;
    #1;
    `CHK("rdata", ex, reg_rdata_out)
    @(posedge clk_in);
    #1;
    `CHK("rdata_idle", 32'h0, reg_rdata_out)
  endtask

  // closing report and verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard, well above the some 1140 cycles the run needs
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  // reset, then clear the reference state; also used mid-run
  task automatic do_reset();
    @(posedge clk_in);
    nrst_in <= 1'h0;
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'h1;
    #1;
    `CHK("rst_flags", 6'h00, fl_now)
    `CHK("rst_data", 32'h0, wb_data_out)
    `CHK("rst_vld", 1'h0, wb_vld_out)
    exp_fl = 6'h00;
    exp_wb = 32'h0;
    exp_idx = 6'h00;
  endtask

  ssa_op_e     scl [3] = '{add_scaled_by_two, add_scaled_by_four, add_scaled_by_eight};
  logic [31:0] va [3] = '{32'h8000_0000, 32'h7000_0000, 32'h0000_0010};
  logic [31:0] vb [3] = '{32'hC000_0001, 32'h0800_0000, 32'h6000_0001};

  // main sequence
  initial begin
    {issue_in, set_flags_in, src1_limm_in, src2_limm_in, short_ptr_in} = 5'h00;
    {reg_wr_in, reg_rd_in, nrst_in} = 3'h0;
    op_in = add_plain;
    {condition_select_in, dest_idx_in, ptr_offset_in, reg_addr_in} = 24'h0;
    {src1_in, src2_in, limm_in, reg_wdata_in} = 128'h0;
    do_reset();
    reg_rd(`SSA_OFS_FLAGS, 32'h0);
    // plain add: sum, zero with carry, signed overflow, no flag update
    exec(add_plain, `SSA_CC_AL, 1'h1, 6'h03, 32'h1, 32'h2, 0);
    exec(add_plain, `SSA_CC_AL, 1'h1, 6'h04, 32'hFFFF_FFFF, 32'h1, 0);
    exec(add_plain, `SSA_CC_AL, 1'h1, 6'h05, 32'h7FFF_FFFF, 32'h1, 0);
    exec(add_plain, `SSA_CC_AL, 1'h0, 6'h06, 32'h8000_0000, 32'h8000_0000, 0);
    // scaled adds by two, four and eight, with sign bits lost in the shift
    foreach (scl[i]) begin
      foreach (va[j]) exec(scl[i], `SSA_CC_AL, 1'h1, 6'h07, va[j], vb[j], 0);
    end
    // saturating add: both limits, sticky flags, no-flag form
    exec(saturating_signed_add, `SSA_CC_AL, 1'h1, 6'h09, 32'h7FFF_FFFF, 32'h1, 0);
    exec(saturating_signed_add, `SSA_CC_AL, 1'h1, 6'h09, 32'h5, 32'h6, 0);
    exec(saturating_signed_add, `SSA_CC_AL, 1'h1, 6'h09, 32'h8000_0000, 32'hFFFF_FFFF, 0);
    reg_wr(`SSA_OFS_FLAGS, 32'h0);
    exec(saturating_signed_add, `SSA_CC_AL, 1'h0, 6'h09, 32'h8000_0000, 32'h8000_0000, 0);
    // null target still computes and sets flags
    exec(add_plain, `SSA_CC_AL, 1'h1, `SSA_NULL_DEST, 32'h0, 32'h0, 0);
    exec(saturating_signed_add, `SSA_CC_AL, 1'h1, `SSA_NULL_DEST, 32'h7FFF_FFFF, 32'h7, 0);
    // operand sources: long immediate either side, short pointer offset
    exec(add_plain, `SSA_CC_AL, 1'h1, 6'h0A, 32'h1111_1111, 32'h0000_0022, 1);
    exec(add_plain, `SSA_CC_AL, 1'h1, 6'h0B, 32'h0000_0100, 32'h2222_2222, 2);
    exec(add_plain, `SSA_CC_AL, 1'h1, 6'h0C, 32'h0000_0100, 32'h0000_001F, 3);
    exec(add_scaled_by_four, `SSA_CC_AL, 1'h1, 6'h0C, 32'h0, 32'h0000_0011, 3);
    // every condition code against every flag pattern; never-codes ask for flags
    for (int p = 0; p < 16; p++) begin
      reg_wr(`SSA_OFS_FLAGS, 32'(p));
      for (int c = 0; c < 32; c++) begin
        exec(add_plain, 5'(c), c >= 16, 6'h0D, 32'(p), 32'h0, 0);
      end
    end
    // register port: mask, read-only result, unmapped places
    reg_wr(`SSA_OFS_FLAGS, 32'hFFFF_FFFF);
    reg_rd(`SSA_OFS_FLAGS, 32'h0000_003F);
    reg_wr(`SSA_OFS_RESULT, 32'h0BAD_0BAD);
    reg_wr(8'h0C, 32'hFFFF_FFFF);
    reg_rd(`SSA_OFS_RESULT, exp_wb);
    reg_rd(8'h08, 32'h0);
    // second reset in mid-run, then traffic again
    do_reset();
    exec(add_plain, `SSA_CC_EQ, 1'h1, 6'h03, 32'h4, 32'h5, 0);
    exec(add_plain, `SSA_CC_NE, 1'h1, 6'h03, 32'h4, 32'h5, 0);
    wrap_up();
  end
endmodule
